// *** src/eiv_defines.svh ***
// Offsets, field positions, reset values and vector addresses of the
// external interrupt and vector block.
// Assumes an 8-bit register port that addresses registers by offset.
// Operation
// - All reset causes vector to word 0x0000.
// - Vectors 1..8: pin, change, timers, converter.
// - Vectors 9..14: timer compares, watchdog, serial.
// - Vector fetched only from an enabled source.
// - Pins interrupt even when driven as outputs.
// - Masked pin-change toggles raise one shared request.
// - Pin-change detection wakes without any clock.
// - Sense field bits 1:0 selects level/change/edges.
// - Low level requests while pin stays low.
// - Edge detection needs the running I/O clock.
// - Low level detection wakes without a clock.
// - Level gone before start-up gives no interrupt.
// - Pin sampled; pulses over one clock detected.
// - External request needs global and own enable.
// - Mask register bits 6,5; others read zero.
// - Pin flag: set on edge, cleared, zero in level.
// - Change flag: set on change, cleared by handler/write.
`ifndef EIV_DEFINES_SVH
`define EIV_DEFINES_SVH

`define EIV_ADR_CTRL      8'h35
`define EIV_ADR_MASK      8'h3B
`define EIV_ADR_FLAG      8'h3A
`define EIV_ADR_PIN_CHANGE_MASK     8'h15
`define EIV_CTRL_RST      8'h00
`define EIV_MASK_RST      8'h00
`define EIV_PIN_CHANGE_MASK_RST     8'h00
`define EIV_CTRL_WMASK    8'h7B
`define EIV_MASK_WMASK    8'h60
`define EIV_PIN_CHANGE_MASK_WMASK   8'h3F
`define EIV_BIT_EXT       6
`define EIV_BIT_PC        5
`define EIV_VEC_RESET     16'h0000
`define EIV_VEC_EXT       16'h0001
`define EIV_VEC_PC        16'h0002
`define EIV_VEC_PERIPH0   16'h0003
`define EIV_VEC_NUM       15
`define EIV_PC_NUM        6
`define EIV_PERIPH_NUM    12

`endif

// *** src/eiv_pkg.sv ***
// Types of the external interrupt and vector block.
// Assumes the constants header sits beside this file.
`default_nettype none
`include "eiv_defines.svh"
package eiv_pkg;

    // Sense codes of the external pin.
    typedef enum logic [1:0] {
        EIV_SENSE_LOW    = 2'h0,
        EIV_SENSE_CHANGE = 2'h1,
        EIV_SENSE_FALL   = 2'h2,
        EIV_SENSE_RISE   = 2'h3
    } eiv_sense_type;

    // State of the edge detector.
    typedef struct packed {
        logic smp;
        logic hit;
    } eiv_edge_state_type;

    // State of the top module.
    typedef struct packed {
        logic [7:0]                   ctrl;
        logic [7:0]                   emask;
        logic [7:0]                   pcmask;
        logic                         ext_flag;
        logic                         pc_flag;
        logic [`EIV_PC_NUM-1:0]       pc_prev;
        logic [7:0]                   rdata;
        logic                         vvld;
        logic [15:0]                  vaddr;
        logic [`EIV_PERIPH_NUM-1:0]   pack;
    } eiv_top_state_type;

endpackage
`default_nettype wire

// *** src/eiv_link_if.sv ***
// Interface joining the top module to its edge detector and priority picker.
// Assumes all parties run on one clock.
`timescale 1ns/100ps
`default_nettype none
`include "eiv_defines.svh"
interface eiv_link_if;
    logic                     pin_s;
    logic                     io_en;
    eiv_pkg::eiv_sense_type   sense;
    logic                     hit;
    logic [`EIV_VEC_NUM-1:0]  req;
    logic                     vld;
    logic [3:0]               idx;

    modport edge_mp (input pin_s, input io_en, input sense, output hit);
    modport prio_mp (input req, output vld, output idx);
    modport top_mp  (output pin_s, output io_en, output sense, output req,
                     input hit, input vld, input idx);
endinterface
`default_nettype wire

// *** src/eiv_edge_detect.sv ***
// Sampled edge and change detector for the external interrupt pin.
// Assumes the pin is synchronous to clk and io_en marks a running I/O clock.
`timescale 1ns/100ps
`default_nettype none
module eiv_edge_detect (
    input  wire logic          clk,
    input  wire logic          rst,
    eiv_link_if.edge_mp        lnk
);
    eiv_pkg::eiv_edge_state_type st_q;
    eiv_pkg::eiv_edge_state_type st_d;

    // The pin is sampled first and compared with the previous sample, so a
    // pulse longer than one clock is never missed while io_en is high.
    always_comb begin
        st_d     = st_q;
        st_d.hit = 1'b0;
        if (lnk.io_en) begin
            st_d.smp = lnk.pin_s;
            case (lnk.sense)
                eiv_pkg::EIV_SENSE_CHANGE: st_d.hit = st_q.smp ^ lnk.pin_s;
                eiv_pkg::EIV_SENSE_FALL:   st_d.hit = st_q.smp & ~lnk.pin_s;
                eiv_pkg::EIV_SENSE_RISE:   st_d.hit = ~st_q.smp & lnk.pin_s;
                default:                   st_d.hit = 1'b0;
            endcase
        end
    end

    // Idle sample is high, the level a pulled-up pin rests at.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{smp: 1'b1, hit: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign lnk.hit = st_q.hit;

    property p_fall_edge;
        @(posedge clk) disable iff (rst)
        lnk.io_en && lnk.sense == eiv_pkg::EIV_SENSE_FALL && st_q.smp
            && !lnk.pin_s |=> lnk.hit;
    endproperty
    a_fall_edge: assert property (p_fall_edge)
        else $error("falling edge not detected");

    property p_clock_stopped;
        @(posedge clk) disable iff (rst)
        !lnk.io_en |=> !lnk.hit;
    endproperty
    a_clock_stopped: assert property (p_clock_stopped)
        else $error("edge seen while I/O clock stopped");
endmodule
`default_nettype wire

// *** src/eiv_vec_prio.sv ***
// Priority picker: lowest pending vector index wins.
// Assumes requests arrive already gated by their enables.
`timescale 1ns/100ps
`default_nettype none
`include "eiv_defines.svh"
module eiv_vec_prio #(
    parameter int NUM = `EIV_VEC_NUM
) (
    eiv_link_if.prio_mp        lnk
);
    // The request vector of the link is fixed in width, so a larger count
    // would read past its top.
    if (NUM < 1 || NUM > `EIV_VEC_NUM) begin : g_bad_num
        $error("eiv_vec_prio: NUM must not exceed the vector count");
    end

    // Scan from the top down so the lowest set index is written last.
    always_comb begin
        lnk.vld = 1'b0;
        lnk.idx = 4'h0;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (lnk.req[i]) begin
                lnk.vld = 1'b1;
                lnk.idx = 4'(i);
            end
        end
    end
endmodule
`default_nettype wire

// *** src/eiv_top.sv ***
// External pin interrupt, pin-change interrupt and vector selection.
// Assumes synchronous pins, a core that pulses vec_ack on handler entry
// and peripheral requests already gated by their own enables.
`timescale 1ns/100ps
`default_nettype none
`include "eiv_defines.svh"
module eiv_top #(
    parameter int PC_NUM     = `EIV_PC_NUM,
    parameter int PERIPH_NUM = `EIV_PERIPH_NUM
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_we,
    input  wire logic                    reg_re,
    output logic [7:0]                   reg_rdata,
    input  wire logic                    ext_irq_pin,
    input  wire logic [PC_NUM-1:0]       pin_change_inputs,
    input  wire logic                    io_clk_en,
    input  wire logic                    cpu_status_word_ie,
    input  wire logic                    reset_cause,
    input  wire logic [PERIPH_NUM-1:0]   periph_req,
    input  wire logic                    vec_ack,
    output logic                         vec_valid,
    output logic [15:0]                  vec_addr,
    output logic [PERIPH_NUM-1:0]        periph_ack,
    output logic                         irq,
    output logic                         wake
);
    // The state struct is sized from the header, so other widths are refused.
    if (PC_NUM != `EIV_PC_NUM || PERIPH_NUM != `EIV_PERIPH_NUM)
    begin : g_bad_param
        $error("eiv_top: PC_NUM and PERIPH_NUM must match the header");
    end

    eiv_pkg::eiv_top_state_type st_q;
    eiv_pkg::eiv_top_state_type st_d;
    eiv_link_if                 lnk ();

    logic                       level_mode;
    logic                       ext_src;
    logic                       ext_req;
    logic                       pc_req;
    logic [PC_NUM-1:0]          pc_diff;
    logic                       pc_hit;
    logic                       wr_ctrl;
    logic                       wr_mask;
    logic                       wr_flag;
    logic                       wr_pcmask;
    logic                       ack_ok;
    logic                       ext_clr;
    logic                       pc_clr;
    logic [PERIPH_NUM-1:0]      pack_w;
    logic [`EIV_VEC_NUM-1:0]    req_w;

    // Edge detection lives in its own module on the sampled pin.
    eiv_edge_detect u_edge (
        .clk (clk),
        .rst (rst),
        .lnk (lnk.edge_mp)
    );

    eiv_vec_prio #(
        .NUM (`EIV_VEC_NUM)
    ) u_prio (
        .lnk (lnk.prio_mp)
    );

    // Pins are read whatever their direction, so driving a pin as an
    // output from software still raises a request.
    assign lnk.pin_s = ext_irq_pin;
    assign lnk.io_en = io_clk_en;
    assign lnk.sense = eiv_pkg::eiv_sense_type'(st_q.ctrl[1:0]);

    // Source terms of the two pin requests.
    assign level_mode = (lnk.sense == eiv_pkg::EIV_SENSE_LOW);
    assign ext_src    = level_mode ? ~ext_irq_pin : st_q.ext_flag;
    assign ext_req    = st_q.emask[`EIV_BIT_EXT] & ext_src;
    assign pc_req     = st_q.emask[`EIV_BIT_PC] & st_q.pc_flag;
    assign pc_diff    = (pin_change_inputs ^ st_q.pc_prev)
                        & st_q.pcmask[PC_NUM-1:0];
    assign pc_hit     = |pc_diff;

    // Register port decode; unmapped addresses are ignored and read zero.
    assign wr_ctrl   = reg_we && reg_addr == `EIV_ADR_CTRL;
    assign wr_mask   = reg_we && reg_addr == `EIV_ADR_MASK;
    assign wr_flag   = reg_we && reg_addr == `EIV_ADR_FLAG;
    assign wr_pcmask = reg_we && reg_addr == `EIV_ADR_PIN_CHANGE_MASK;

    // Handler entry acts on the vector that the core currently sees.
    assign ack_ok  = vec_ack && st_q.vvld;
    assign ext_clr = (ack_ok && st_q.vaddr == `EIV_VEC_EXT)
                     || (wr_flag && reg_wdata[`EIV_BIT_EXT]);
    assign pc_clr  = (ack_ok && st_q.vaddr == `EIV_VEC_PC)
                     || (wr_flag && reg_wdata[`EIV_BIT_PC]);

    // One acknowledge pulse per peripheral so it can drop its own flag.
    for (genvar k = 0; k < PERIPH_NUM; k++) begin : g_pack
        assign pack_w[k] = ack_ok
                           && st_q.vaddr == (`EIV_VEC_PERIPH0 + 16'(k));
    end

    // Reset ignores the global enable; every interrupt needs it.
    // Vector index equals word address, one word per slot.
    assign req_w[0] = reset_cause;
    assign req_w[1] = cpu_status_word_ie & ext_req;
    assign req_w[2] = cpu_status_word_ie & pc_req;
    assign req_w[`EIV_VEC_NUM-1:3] = cpu_status_word_ie ? periph_req
                                     : '0;
    assign lnk.req = req_w;

    // Next state: registers, flags, read data and the vector register.
    always_comb begin
        st_d         = st_q;
        st_d.pc_prev = pin_change_inputs;
        st_d.pack    = pack_w;
        if (wr_ctrl) begin
            st_d.ctrl = reg_wdata & `EIV_CTRL_WMASK;
        end
        if (wr_mask) begin
            st_d.emask = reg_wdata & `EIV_MASK_WMASK;
        end
        if (wr_pcmask) begin
            st_d.pcmask = reg_wdata & `EIV_PIN_CHANGE_MASK_WMASK;
        end
        // A hit in the clearing cycle wins, so no event is lost.
        st_d.ext_flag = (st_q.ext_flag & ~ext_clr) | lnk.hit;
        if (level_mode) begin
            st_d.ext_flag = 1'b0;
        end
        st_d.pc_flag = (st_q.pc_flag & ~pc_clr) | pc_hit;
        // Read data stand only in the cycle after the strobe.
        st_d.rdata = 8'h00;
        if (reg_re) begin
            case (reg_addr)
                `EIV_ADR_CTRL:  st_d.rdata = st_q.ctrl;
                `EIV_ADR_MASK:  st_d.rdata = st_q.emask;
                `EIV_ADR_PIN_CHANGE_MASK: st_d.rdata = st_q.pcmask;
                `EIV_ADR_FLAG: begin
                    st_d.rdata[`EIV_BIT_EXT] = st_q.ext_flag;
                    st_d.rdata[`EIV_BIT_PC]  = st_q.pc_flag;
                end
                default:        st_d.rdata = 8'h00;
            endcase
        end
        // No vector is offered without an enabled pending source.
        st_d.vvld  = lnk.vld;
        st_d.vaddr = {12'h000, lnk.idx};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{ctrl: `EIV_CTRL_RST, emask: `EIV_MASK_RST,
                      pcmask: `EIV_PIN_CHANGE_MASK_RST, ext_flag: 1'b0,
                      pc_flag: 1'b0, pc_prev: '0, rdata: 8'h00,
                      vvld: 1'b0, vaddr: `EIV_VEC_RESET, pack: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata  = st_q.rdata;
    assign vec_valid  = st_q.vvld;
    assign vec_addr   = st_q.vaddr;
    assign periph_ack = st_q.pack;
    // Level interrupt line, high while an unmasked pin request stands.
    assign irq        = ext_req | pc_req;
    // Wake needs no clock edge: a low level or a masked pin difference
    // reaches the output through gates only. A level that vanishes before
    // start-up ends wakes the part but leaves no request behind.
    assign wake = (level_mode & st_q.emask[`EIV_BIT_EXT] & ~ext_irq_pin)
                  | (st_q.emask[`EIV_BIT_PC] & pc_hit);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_reset_vec;
        reset_cause |=> vec_valid && vec_addr == 16'h0000;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset cause did not select word zero");

    property p_ext_vec;
        !reset_cause && cpu_status_word_ie && ext_req
            |=> vec_valid && vec_addr == 16'h0001;
    endproperty
    a_ext_vec: assert property (p_ext_vec)
        else $error("external pin request not at word one");

    property p_pc_vec;
        !reset_cause && cpu_status_word_ie && !ext_req && pc_req
            |=> vec_addr == 16'h0002;
    endproperty
    a_pc_vec: assert property (p_pc_vec)
        else $error("pin change request not at word two");

    property p_periph_vec;
        !reset_cause && cpu_status_word_ie && !ext_req && !pc_req
            && periph_req[5:0] == 6'h00 && periph_req[6]
            |=> vec_addr == 16'h0009;
    endproperty
    a_periph_vec: assert property (p_periph_vec)
        else $error("timer compare B not at word nine");

    property p_no_source;
        req_w == '0 |=> !vec_valid;
    endproperty
    a_no_source: assert property (p_no_source)
        else $error("vector offered with no enabled source");

    property p_global_off;
        !reset_cause && !cpu_status_word_ie |=> !vec_valid;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("interrupt vector offered with global enable off");

    property p_pc_set;
        pc_hit |=> st_q.pc_flag ##1 st_q.pc_flag || $past(pc_clr);
    endproperty
    a_pc_set: assert property (p_pc_set)
        else $error("masked pin toggle did not set change flag");

    property p_pc_w1c;
        wr_flag && reg_wdata[5] && !pc_hit |=> !st_q.pc_flag;
    endproperty
    a_pc_w1c: assert property (p_pc_w1c)
        else $error("change flag not cleared by writing one");

    property p_level_flag;
        level_mode |=> !st_q.ext_flag;
    endproperty
    a_level_flag: assert property (p_level_flag)
        else $error("pin flag set in low level mode");

    property p_level_req;
        level_mode && st_q.emask[6] && !ext_irq_pin |-> irq && wake;
    endproperty
    a_level_req: assert property (p_level_req)
        else $error("low level did not request");

    property p_mask_read;
        reg_re && reg_addr == 8'h3B
            |=> reg_rdata[7] == 1'b0 && reg_rdata[4:0] == 5'h00
            ##1 reg_rdata == 8'h00 || $past(reg_re);
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask register reserved bits not zero");

    property p_ext_ack;
        vec_ack && vec_valid && vec_addr == 16'h0001 && !lnk.hit
            |=> !st_q.ext_flag;
    endproperty
    a_ext_ack: assert property (p_ext_ack)
        else $error("handler entry left pin flag set");

    c_ext_taken:  cover property (vec_ack && vec_valid
                                  && vec_addr == 16'h0001);
    c_pc_taken:   cover property (vec_ack && vec_valid
                                  && vec_addr == 16'h0002);
    c_level_wake: cover property (level_mode && wake);
    c_set_clear:  cover property (pc_hit && pc_clr);
endmodule
`default_nettype wire

// *** sim/eiv_core_model.sv ***
// Behavioural model of the processor core's interrupt entry.
// Assumes vec_valid comes registered from the block on the same clock.
`timescale 1ns/100ps
`default_nettype none
module eiv_core_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        en,
    input  wire logic [3:0]  ack_dly,
    input  wire logic        vec_valid,
    output logic             vec_ack
);
    int wait_cnt;
    int guard_cnt;

    // Enter a handler after ack_dly cycles of a standing offer.  The guard
    // keeps a stale offer from being taken twice while it falls away.
    always @(posedge clk) begin
        vec_ack <= 1'b0;
        if (rst || !en) begin
            wait_cnt <= 0;
            guard_cnt <= 0;
        end else if (guard_cnt > 0) begin
            guard_cnt <= guard_cnt - 1;
        end else if (vec_valid !== 1'b1) begin
            wait_cnt <= 0;
        end else if (wait_cnt >= int'(ack_dly)) begin
            vec_ack <= 1'b1;
            wait_cnt <= 0;
            guard_cnt <= 6;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench of the external interrupt and vector block.
// Assumes the design sources and eiv_defines.svh are on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "eiv_defines.svh"
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_we = 1'b0;
    logic        reg_re = 1'b0;
    logic [7:0]  reg_rdata;
    logic        pin = 1'b1;
    logic [5:0]  pcin = 6'h00;
    logic        io_en = 1'b1;
    logic        ie = 1'b0;
    logic        rcause = 1'b0;
    logic [11:0] periph_req = 12'h000;
    logic        vec_ack;
    logic        vec_valid;
    logic [15:0] vec_addr;
    logic [11:0] periph_ack;
    logic        irq;
    logic        wake;
    logic        core_en = 1'b0;
    logic [3:0]  ack_dly = 4'h0;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc_cnt = 0;

    eiv_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .ext_irq_pin(pin), .pin_change_inputs(pcin),
        .io_clk_en(io_en), .cpu_status_word_ie(ie), .reset_cause(rcause),
        .periph_req(periph_req), .vec_ack(vec_ack), .vec_valid(vec_valid),
        .vec_addr(vec_addr), .periph_ack(periph_ack), .irq(irq),
        .wake(wake));

    eiv_core_model i_core (.clk(clk), .rst(rst), .en(core_en),
        .ack_dly(ack_dly), .vec_valid(vec_valid), .vec_ack(vec_ack));

    // A 200 MHz clock; a hang is cut short well past the expected run.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Outputs are looked at just after the edge, once its updates landed.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // Wait, bounded, for an offer and compare it with the expected slot.
    task automatic chk_vec(input logic [15:0] exp);
        int i;
        // Step off the launching edge before the first look at the offer.
        #1;
        for (i = 0; i < 20 && vec_valid !== 1'b1; i++) settle(1);
        chk({vec_valid, vec_addr[14:0]}, {1'b1, exp[14:0]});
    endtask

    task automatic t_regs;
        rdc(`EIV_ADR_CTRL, 8'h00);
        rdc(`EIV_ADR_MASK, 8'h00);
        wr(`EIV_ADR_MASK, 8'hFF);
        rdc(`EIV_ADR_MASK, 8'h60);
        wr(`EIV_ADR_CTRL, 8'hFF);
        rdc(`EIV_ADR_CTRL, 8'h7B);
        wr(`EIV_ADR_PIN_CHANGE_MASK, 8'hFF);
        rdc(`EIV_ADR_PIN_CHANGE_MASK, 8'h3F);
        wr(`EIV_ADR_PIN_CHANGE_MASK, 8'h00);
        wr(8'h40, 8'hFF);
        rdc(8'h40, 8'h00);
        wr(`EIV_ADR_CTRL, 8'h00);
        wr(`EIV_ADR_MASK, 8'h40);
    endtask

    // Drive the pin for several clocks so that a sampled edge is caught.
    task automatic t_edge(input logic [1:0] s, input logic lvl,
                          input logic [7:0] exp);
        wr(`EIV_ADR_CTRL, {6'h00, s});
        @(posedge clk);
        pin <= lvl;
        settle(4);
        chk({15'h0, irq}, {15'h0, exp[6]});
        rdc(`EIV_ADR_FLAG, exp);
        wr(`EIV_ADR_FLAG, 8'h40);
        rdc(`EIV_ADR_FLAG, 8'h00);
    endtask

    task automatic t_level;
        wr(`EIV_ADR_CTRL, 8'h00);
        @(posedge clk);
        pin <= 1'b0;
        settle(1);
        chk({15'h0, wake}, 16'h0001);
        settle(3);
        chk({15'h0, irq}, 16'h0001);
        chk({15'h0, vec_valid}, 16'h0000);
        rdc(`EIV_ADR_FLAG, 8'h00);
        @(posedge clk);
        ie <= 1'b1;
        chk_vec(16'h0001);
        @(posedge clk);
        ie <= 1'b0;
        pin <= 1'b1;
        settle(2);
        chk({14'h0, irq, wake}, 16'h0000);
    endtask

    // With the I/O clock stopped an edge must pass unseen.
    task automatic t_io_stop;
        wr(`EIV_ADR_CTRL, 8'h02);
        @(posedge clk);
        io_en <= 1'b0;
        pin <= 1'b0;
        settle(4);
        rdc(`EIV_ADR_FLAG, 8'h00);
        @(posedge clk);
        pin <= 1'b1;
        settle(2);
        @(posedge clk);
        io_en <= 1'b1;
    endtask

    // A falling edge taken by the core: handler entry must drop the flag.
    task automatic t_ext_ack;
        @(posedge clk);
        core_en <= 1'b1;
        ie <= 1'b1;
        pin <= 1'b0;
        chk_vec(16'h0001);
        settle(10);
        rdc(`EIV_ADR_FLAG, 8'h00);
        chk({15'h0, vec_valid}, 16'h0000);
        @(posedge clk);
        ie <= 1'b0;
        core_en <= 1'b0;
        pin <= 1'b1;
    endtask

    task automatic t_pin_change;
        wr(`EIV_ADR_MASK, 8'h20);
        wr(`EIV_ADR_PIN_CHANGE_MASK, 8'h01);
        // Wake stands only until the next sample, so look right after it.
        @(posedge clk);
        pcin <= 6'h02;
        #1;
        chk({15'h0, wake}, 16'h0000);
        settle(3);
        rdc(`EIV_ADR_FLAG, 8'h00);
        @(posedge clk);
        pcin <= 6'h03;
        #1;
        chk({15'h0, wake}, 16'h0001);
        settle(3);
        rdc(`EIV_ADR_FLAG, 8'h20);
        chk({15'h0, irq}, 16'h0001);
        @(posedge clk);
        core_en <= 1'b1;
        ie <= 1'b1;
        chk_vec(16'h0002);
        settle(10);
        rdc(`EIV_ADR_FLAG, 8'h00);
        @(posedge clk);
        ie <= 1'b0;
    endtask

    // Each peripheral slot in turn, taken promptly and slowly by the core.
    task automatic t_vectors;
        int k;
        int i;
        wr(`EIV_ADR_MASK, 8'h00);
        @(posedge clk);
        ie <= 1'b1;
        settle(3);
        chk({15'h0, vec_valid}, 16'h0000);
        for (k = 0; k < 12; k++) begin
            @(posedge clk);
            ack_dly <= (k % 2 == 1) ? 4'h5 : 4'h0;
            periph_req <= 12'h001 << k;
            chk_vec(16'(k + 3));
            for (i = 0; i < 20 && periph_ack == 12'h000; i++) settle(1);
            chk({4'h0, periph_ack}, 16'h0001 << k);
            @(posedge clk);
            periph_req <= 12'h000;
            settle(8);
        end
    endtask

    task automatic t_priority;
        @(posedge clk);
        core_en <= 1'b0;
        ie <= 1'b0;
        rcause <= 1'b1;
        periph_req <= 12'h801;
        chk_vec(16'h0000);
        @(posedge clk);
        rcause <= 1'b0;
        settle(3);
        chk({15'h0, vec_valid}, 16'h0000);
        @(posedge clk);
        ie <= 1'b1;
        chk_vec(16'h0003);
        @(posedge clk);
        periph_req <= 12'h000;
        ie <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_edge(2'h2, 1'b0, 8'h40);
        t_edge(2'h2, 1'b1, 8'h00);
        t_edge(2'h3, 1'b0, 8'h00);
        t_edge(2'h3, 1'b1, 8'h40);
        t_edge(2'h1, 1'b0, 8'h40);
        t_edge(2'h1, 1'b1, 8'h40);
        t_level();
        t_io_stop();
        t_ext_ack();
        t_pin_change();
        t_vectors();
        t_priority();
        summarize();
    end
endmodule
`default_nettype wire
